// ### shared/lmsp_regs.vh
// Summary of operation
// - Input is reference; taps see delayed input
// - Prediction sums coefficient times delayed sample
// - Error equals reference minus prediction
// - Coefficient gains step times error times sample
// - Every coefficient adapts on every sample while adapt_en is set
// - Error stream is the cleaned output
// - Sixteen taps, 16-bit signed data, reloadable
`ifndef LMSP_REGS_VH
`define LMSP_REGS_VH
`define LMSP_TAPS       16
`define LMSP_DATA_W     16
`define LMSP_COEF_W     16
`define LMSP_MAX_DELAY  32
`define LMSP_DELAY_W    5
`define LMSP_SHIFT_W    5
`define LMSP_FRAC       15
`define LMSP_COEF_RST   16'h0000
`define LMSP_ST_IDLE    2'd0
`define LMSP_ST_PRED    2'd1
`define LMSP_ST_ADAPT   2'd2
`define LMSP_ST_OUT     2'd3
`endif

// ### core/lmsp_mac.v
`timescale 1ns/100ps
// Signed multiply with saturating accumulate, one term per call
module lmsp_mac #(
  parameter AW = 40
) (
  // Operands
  input  wire signed [15:0]   a,
  input  wire signed [15:0]   b,
  input  wire signed [AW-1:0] acc_in,
  // Result
  output wire signed [AW-1:0] acc_out
);
  wire signed [31:0] prod;
  wire signed [AW:0] sum;
  assign prod = a * b;
  assign sum  = {acc_in[AW-1], acc_in} + {{(AW+1-32){prod[31]}}, prod};
  // Clamp on overflow rather than wrap
  assign acc_out = (sum[AW] != sum[AW-1]) ?
                   (sum[AW] ? {1'b1, {(AW-1){1'b0}}} : {1'b0, {(AW-1){1'b1}}}) :
                   sum[AW-1:0];
endmodule // lmsp_mac

// ### core/lmsp_filter.v
`timescale 1ns/100ps
`include "lmsp_regs.vh"
// Linear-prediction LMS filter, one tap per clock
module lmsp_filter #(
  parameter TAPS = `LMSP_TAPS,
  parameter MAXD = `LMSP_MAX_DELAY,
  parameter AW   = 40
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        clk_en,
  // Sample in
  input  wire        in_valid,
  input  wire [15:0] in_sample,
  // Settings from the surrounding logic
  input  wire [4:0]  delta,
  input  wire [4:0]  step_shift,
  input  wire        adapt_en,
  // Coefficient reload
  input  wire        coef_wr,
  input  wire [3:0]  coef_idx,
  input  wire [15:0] coef_data,
  // Outputs
  output reg         busy_r,
  output reg         out_valid_r,
  output reg  [15:0] err_out_r,
  output reg  [15:0] pred_out_r
);
  reg signed [15:0] hist_r [0:MAXD+TAPS-1];
  reg signed [15:0] coef_r [0:TAPS-1];
  reg [1:0]         state_r;
  reg [4:0]         tap_r;
  reg signed [AW-1:0] acc_r;
  reg signed [15:0] err_r;
  reg signed [15:0] ref_r;
  wire signed [AW-1:0] mac_out;
  wire signed [15:0]   tap_x;
  wire signed [31:0]   upd_prod;
  wire signed [31:0]   upd_scaled;
  wire signed [16:0]   coef_sum;
  integer i;

  // Clamp a wide value to 16 signed bits
  function [15:0] sat16;
    input signed [AW-1:0] v;
    begin
      if (v > $signed(40'sh0000007fff))
        sat16 = 16'h7fff;
      else if (v < $signed(-40'sh0000008000))
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  // Tap sample x(n - delta - k); index 0 holds the newest sample
  assign tap_x = hist_r[{1'b0, delta} + {1'b0, tap_r}];

  // Coefficients are Q15 fractions, so the sum is scaled back before use
  wire signed [AW-1:0] acc_q;
  wire signed [15:0]   pred_sat;
  wire signed [16:0]   err_wide;
  wire signed [15:0]   err_sat;
  assign acc_q    = acc_r >>> `LMSP_FRAC;
  assign pred_sat = sat16(acc_q);
  // Error built from the clamped prediction, so both outputs stay consistent
  assign err_wide = {ref_r[15], ref_r} - {pred_sat[15], pred_sat};
  assign err_sat  = (err_wide[16] != err_wide[15]) ?
                    {err_wide[16], {15{~err_wide[16]}}} : err_wide[15:0];

  lmsp_mac #(.AW(AW)) u_mac (
    .a       (coef_r[tap_r[3:0]]),
    .b       (tap_x),
    .acc_in  (acc_r),
    .acc_out (mac_out)
  );

  // Step size is a power of two, so the multiply becomes a shift
  assign upd_prod   = err_r * tap_x;
  assign upd_scaled = upd_prod >>> (step_shift + `LMSP_FRAC);
  assign coef_sum   = {coef_r[tap_r[3:0]][15], coef_r[tap_r[3:0]]} +
                      ((upd_scaled > 32'sd32767) ? 17'sh07fff :
                       (upd_scaled < -32'sd32768) ? 17'sh18000 : upd_scaled[16:0]);

  // Main sequence: shift in, predict, error, adapt
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r     <= `LMSP_ST_IDLE;
      tap_r       <= 5'h00;
      acc_r       <= {AW{1'b0}};
      err_r       <= 16'h0000;
      ref_r       <= 16'h0000;
      busy_r      <= 1'b0;
      out_valid_r <= 1'b0;
      err_out_r   <= 16'h0000;
      pred_out_r  <= 16'h0000;
      for (i = 0; i < MAXD+TAPS; i = i + 1)
        hist_r[i] <= 16'h0000;
      for (i = 0; i < TAPS; i = i + 1)
        coef_r[i] <= `LMSP_COEF_RST;
    end else if (clk_en) begin
      out_valid_r <= 1'b0;
      case (state_r)
        `LMSP_ST_IDLE: begin
          // Reload only between samples so adaption never races it
          if (coef_wr)
            coef_r[coef_idx] <= coef_data;
          if (in_valid) begin
            ref_r     <= in_sample;
            hist_r[0] <= in_sample;
            for (i = 1; i < MAXD+TAPS; i = i + 1)
              hist_r[i] <= hist_r[i-1];
            acc_r   <= {AW{1'b0}};
            tap_r   <= 5'h00;
            busy_r  <= 1'b1;
            state_r <= `LMSP_ST_PRED;
          end
        end
        `LMSP_ST_PRED: begin
          acc_r <= mac_out;
          if (tap_r == TAPS-1) begin
            tap_r   <= 5'h00;
            state_r <= `LMSP_ST_OUT;
          end else
            tap_r <= tap_r + 5'h01;
        end
        `LMSP_ST_OUT: begin
          // Error saturates at the 16-bit range
          err_r       <= err_sat;
          err_out_r   <= err_sat;
          pred_out_r  <= pred_sat;
          out_valid_r <= 1'b1;
          state_r     <= adapt_en ? `LMSP_ST_ADAPT : `LMSP_ST_IDLE;
          busy_r      <= adapt_en;
        end
        `LMSP_ST_ADAPT: begin
          coef_r[tap_r[3:0]] <= (coef_sum[16] != coef_sum[15]) ?
                                (coef_sum[16] ? 16'h8000 : 16'h7fff) :
                                coef_sum[15:0];
          if (tap_r == TAPS-1) begin
            tap_r   <= 5'h00;
            busy_r  <= 1'b0;
            state_r <= `LMSP_ST_IDLE;
          end else
            tap_r <= tap_r + 5'h01;
        end
        default: state_r <= `LMSP_ST_IDLE;
      endcase
    end
  end
endmodule // lmsp_filter

// ### dv/lmsp_properties.sv
`timescale 1ns/100ps
// Port-level checks on the filter
module lmsp_chk (
  // Control and sample in
  input wire        sys_clk,
  input wire        rst,
  input wire        clk_en,
  input wire        in_valid,
  input wire        adapt_en,
  input wire [15:0] in_sample,
  // Results
  input wire        busy_r,
  input wire        out_valid_r,
  input wire [15:0] err_out_r,
  input wire [15:0] pred_out_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  reg  [15:0]        d_r;
  wire               tk = clk_en && in_valid && !busy_r;
  wire signed [16:0] df = $signed(d_r) - $signed(pred_out_r);
  // Saturated reference minus prediction
  wire [15:0] e_x = (df[16] != df[15]) ? {df[16], {15{~df[16]}}} : df[15:0];
  // Hold the reference until its result is out
  always @(posedge sys_clk) if (tk) d_r <= in_sample;
  property p_busy; tk |=> busy_r; endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_lat; tk |-> ##18 out_valid_r; endproperty
  a_lat: assert property (p_lat) else $error("result late");
  property p_early; tk |=> !out_valid_r [*8]; endproperty
  a_early: assert property (p_early) else $error("result early");
  property p_err; out_valid_r |-> err_out_r == e_x; endproperty
  a_err: assert property (p_err) else $error("bad error value");
  property p_pulse; out_valid_r |=> !out_valid_r; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_hold; !out_valid_r |-> $stable({err_out_r, pred_out_r}); endproperty
  a_hold: assert property (p_hold) else $error("output moved");
  property p_own; out_valid_r |-> $past(busy_r); endproperty
  a_own: assert property (p_own) else $error("result without sample");
  property p_adapt; out_valid_r && adapt_en |-> busy_r [*8]; endproperty
  a_adapt: assert property (p_adapt) else $error("adapt pass skipped");
  c_take: cover property (tk);
  c_fixed: cover property (out_valid_r && !adapt_en);
  c_adapt: cover property (out_valid_r && adapt_en);
endmodule // lmsp_chk
bind lmsp_filter lmsp_chk chk_u (.sys_clk, .rst, .clk_en, .in_valid, .in_sample, .adapt_en,
  .busy_r, .out_valid_r, .err_out_r, .pred_out_r);

// ### dv/lmsp_src.sv
`timescale 1ns/100ps
// Sample source standing in for the control logic
module lmsp_src (
  input  wire        sys_clk,
  input  wire        go,
  input  wire        busy_r,
  output reg         in_valid,
  output reg  [15:0] in_sample
);
  integer seed = 32'h6635;
  wire    ok   = go && !busy_r && !in_valid;
  initial begin
    in_valid = 1'b0;
    in_sample = 16'h0000;
  end
  // One-edge pulse while idle; data scrambled between samples
  always @(negedge sys_clk) begin
    in_valid <= ok;
    in_sample <= ok ? 16'($random(seed)) : ~in_sample;
  end
endmodule // lmsp_src

// ### dv/lmsp_filter_tb.sv
`timescale 1ns/100ps
`include "lmsp_regs.vh"
module lmsp_filter_tb;
  localparam DLY = 3;
  localparam SHF = 4;
  reg         sys_clk = 0, rst = 1, go = 0, adapt_en = 0, coef_wr = 0, ld = 0;
  reg  [3:0]  coef_idx = 4'h0;
  reg  [15:0] coef_data = 16'h0000;
  wire        in_valid, busy_r, out_valid_r;
  wire [15:0] in_sample, err_out_r, pred_out_r;
  integer     err_total = 0, num_checks = 0, cyc = 0, k;
  int         mhist[0:47];
  int         mcoef[0:15];
  int         pr, er;
  longint     acc;
  reg  [15:0] exp_q[$];
  reg  [15:0] pred_q[$];
  initial forever #50 sys_clk = ~sys_clk;
  lmsp_src src_u (.sys_clk, .go, .busy_r, .in_valid, .in_sample);
  lmsp_filter dut_u (.sys_clk, .rst, .clk_en(1'b1), .in_valid, .in_sample, .delta(5'h03),
    .step_shift(5'h04), .adapt_en, .coef_wr, .coef_idx, .coef_data,
    .busy_r, .out_valid_r, .err_out_r, .pred_out_r);
  // Clamp to the 16-bit signed range
  function automatic int sat(input longint v);
    sat = (v > 32767) ? 32767 : (v < -32768) ? -32768 : int'(v);
  endfunction
  task complete_run;
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] want);
    num_checks++;
    if (got !== want) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Reference model: Q15 taps, power-of-two step, saturating results
  always @(posedge sys_clk) begin
    if (!rst && coef_wr && !busy_r)
      mcoef[coef_idx] = $signed(coef_data);
    if (!rst && in_valid && !busy_r) begin
      for (k = 47; k > 0; k = k - 1)
        mhist[k] = mhist[k-1];
      mhist[0] = $signed(in_sample);
      acc = 0;
      for (k = 0; k < 16; k = k + 1)
        acc = acc + longint'(mcoef[k]) * mhist[DLY+k];
      pr = sat(acc >>> `LMSP_FRAC);
      er = sat(longint'(mhist[0]) - pr);
      exp_q.push_back(er[15:0]);
      pred_q.push_back(pr[15:0]);
      if (adapt_en)
        for (k = 0; k < 16; k = k + 1)
          mcoef[k] = sat(mcoef[k] + ((er * mhist[DLY+k]) >>> (`LMSP_FRAC + SHF)));
    end
  end
  // Results are compared mid-cycle while the valid pulse stands
  always @(negedge sys_clk) if (out_valid_r) begin
    if (exp_q.size() == 0) begin
      err_total++;
      $display("ERROR %0t: result with no sample", $time);
    end else begin
      chk(err_out_r, exp_q.pop_front());
      chk(pred_out_r, pred_q.pop_front());
    end
  end
  // One real load while idle; reload attempts while busy must be ignored
  always @(negedge sys_clk) begin
    coef_wr   <= ld || (go && busy_r);
    coef_idx  <= ld ? 4'h2 : 4'h5;
    coef_data <= ld ? 16'h4000 : 16'h7fff;
  end
  always @(posedge sys_clk) if (++cyc > 3000) begin
    err_total++;
    complete_run;
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 0;
    ld <= 1'b1;
    @(negedge sys_clk);
    ld <= 1'b0;
    repeat (2) @(negedge sys_clk);
    go = 1;
    repeat (400) @(negedge sys_clk);
    go = 0;
    repeat (40) @(negedge sys_clk);
    adapt_en = 1;
    go = 1;
    repeat (700) @(negedge sys_clk);
    go = 0;
    repeat (40) @(negedge sys_clk);
    if (exp_q.size() != 0) begin
      err_total++;
      $display("ERROR %0t: results missing", $time);
    end
    complete_run;
  end
endmodule // lmsp_filter_tb
